// >>> rtl/ufc_uart.sv
// Purpose: Full-duplex UART with 6-byte receive FIFO and RTS/CTS flow control
// Assumes: Avalon-MM slave with waitrequest, word addressed, 32-bit data
// Notes:   Events are sticky, write one to clear; set beats clear
`timescale 1ns/1ns
module ufc_uart
   import ufc_pkg::*;
#(
   parameter int FIFO_DEPTH = 6,
   parameter int RTS_ROOM   = 4
) (
   input  wire logic        core_clk,
   input  wire logic        rst,
   input  wire logic [2:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   input  wire logic        rxdIn,
   input  wire logic        ctsNIn,
   output logic             txdOut,
   output logic             txdOe,
   output logic             rtsNOut,
   output logic             rtsNOe
);
   // Refuse sizes that the 3-bit pointers and counter cannot serve
   if (FIFO_DEPTH < 2 || FIFO_DEPTH > 7 || RTS_ROOM >= FIFO_DEPTH) begin : g_bad_size
      $error("ufc_uart: unsupported FIFO_DEPTH or RTS_ROOM");
   end
   localparam logic [2:0] DEPTH   = 3'(FIFO_DEPTH);
   localparam logic [2:0] RTS_LVL = 3'(FIFO_DEPTH - RTS_ROOM);
   typedef enum logic [0:0] {TX_IDLE, TX_SHIFT} ufc_tx_e;
   typedef enum logic [2:0] {RX_IDLE, RX_START, RX_BITS, RX_BRK, RX_HIGH} ufc_rx_e;
   ufc_cfg_s    cfg_q;
   ufc_evt_s    evt_q, evtSet;
   ufc_err_s    err_q, errSet;
   logic [15:0] baud_q;
   logic        waitReq_q;
   logic [31:0] rdData_q;
   logic        rxdMeta_q, rxdSync_q, ctsMeta_q, ctsSync_q;
   // Transmit state
   ufc_tx_e     txState_q;
   logic        txOn_q, txSusp_q, txPend_q, txLine_q;
   logic [7:0]  txBuf_q;
   logic [10:0] txSh_q;
   logic [15:0] txCnt_q;
   logic [3:0]  txBit_q;
   // Receive state
   ufc_rx_e     rxState_q;
   logic        rxOn_q;
   logic [15:0] rxCnt_q;
   logic [3:0]  rxBit_q;
   logic [8:0]  rxSh_q;
   logic [23:0] toCnt_q;
   logic [7:0]  fifoMem_q [FIFO_DEPTH];
   logic [2:0]  wrPtr_q, rdPtr_q, fifoCnt_q;
   logic [7:0]  rxd_q;
   logic        rxdValid_q, rtsHold_q, rtsN_q;

   // Bus decode
   wire [7:0] addrB    = {3'h0, avs_address, 2'h0};
   wire       access   = (avs_read | avs_write) & ~waitReq_q;
   wire       wrAcc    = access & avs_write;
   wire       rdAcc    = access & avs_read;
   wire       wrTasks  = wrAcc & (addrB == OFF_TASKS);
   wire       wrEvents = wrAcc & (addrB == OFF_EVENTS);
   wire       wrErrsrc = wrAcc & (addrB == OFF_ERRSRC);
   wire       wrConfig = wrAcc & (addrB == OFF_CONFIG);
   wire       wrBaud   = wrAcc & (addrB == OFF_BAUD);
   wire       wrTxd    = wrAcc & (addrB == OFF_TXD);
   wire       rdRxd    = rdAcc & (addrB == OFF_RXD);
   wire [4:0] task_w   = wrTasks ? avs_writedata[4:0] : 5'h0;
   wire       start_receive_task  = task_w[TB_START_RX];
   wire       stop_receive_task   = task_w[TB_STOP_RX] | task_w[TB_SUSPEND];
   wire       start_transmit_task  = task_w[TB_START_TX];
   wire       stop_transmit_task   = task_w[TB_STOP_TX];
   wire       suspend  = task_w[TB_SUSPEND];

   // Pins reach the logic only while enabled and connected
   wire rxLine   = (cfg_q.enable & cfg_q.connect[0]) ? rxdSync_q : 1'b1;
   wire ctsOn    = cfg_q.enable & cfg_q.connect[1] & ~ctsSync_q;
   wire ctsOk    = ~cfg_q.flow | ctsOn;
   wire [3:0] txBits = cfg_q.parity ? 4'ha : 4'h9;   // last bit index
   wire [3:0] rxData = cfg_q.parity ? 4'h9 : DATA_BITS;
   wire txParity = ^txBuf_q;
   wire txEnd    = (txState_q == TX_SHIFT) & (txCnt_q == 16'h0) & (txBit_q == txBits);
   wire txLoad   = (txState_q == TX_IDLE) & txOn_q & ~txSusp_q & txPend_q & ctsOk & ~stop_transmit_task;
   wire rxActive = rxOn_q | (toCnt_q != 24'h0);
   wire rxAtStop = (rxState_q == RX_BITS) & (rxCnt_q == 16'h0) & (rxBit_q == rxData);
   wire [7:0] rxByte = cfg_q.parity ? rxSh_q[7:0] : rxSh_q[8:1];
   wire rxPush   = rxAtStop & rxLine;
   wire rxdLoad  = (~rxdValid_q | rdRxd) & (fifoCnt_q != 3'h0);
   wire fifoPop  = rxdLoad;
   wire [2:0] wrNext = (wrPtr_q == DEPTH - 3'h1) ? 3'h0 : wrPtr_q + 3'h1;
   wire [2:0] rdNext = (rdPtr_q == DEPTH - 3'h1) ? 3'h0 : rdPtr_q + 3'h1;
   wire fifoFull = fifoCnt_q == DEPTH;
   wire rtsOn    = ~cfg_q.flow | (rxOn_q & ~rtsHold_q);
   wire [23:0] toLoad = 24'(baud_q) * 24'(RX_TO_BITS);

   // Event and error sources
   always_comb begin
      evtSet.txDone    = txEnd;
      evtSet.rxReady   = rxdLoad;
      evtSet.rxTimeout = (toCnt_q == 24'h1);
      errSet.framing   = rxAtStop & ~rxLine;
      errSet.parity    = rxPush & cfg_q.parity & (^rxSh_q);
      errSet.brk       = (rxState_q == RX_BRK) & (rxCnt_q == 16'h0) & ~rxLine;
      evtSet.err       = |errSet;
   end

   // Input synchronisers
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         {rxdMeta_q, rxdSync_q, ctsMeta_q, ctsSync_q} <= 4'hf;
      end else begin
         {rxdMeta_q, ctsMeta_q} <= {rxdIn, ctsNIn};
         {rxdSync_q, ctsSync_q} <= {rxdMeta_q, ctsMeta_q};
      end
   end

   // Bus slave: one wait cycle, then answer
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         waitReq_q <= 1'b1;
         rdData_q  <= 32'h0;
      end else begin
         waitReq_q <= ~((avs_read | avs_write) & waitReq_q);
         if (avs_read & waitReq_q) begin
            case (addrB)
               OFF_EVENTS: rdData_q <= 32'(evt_q);
               OFF_ERRSRC: rdData_q <= 32'(err_q);
               OFF_CONFIG: rdData_q <= 32'(cfg_q);
               OFF_BAUD:   rdData_q <= 32'(baud_q);
               OFF_RXD:    rdData_q <= 32'(rxd_q);
               OFF_TXD:    rdData_q <= 32'(txBuf_q);
               OFF_STATUS: rdData_q <= {23'h0, rxdValid_q, fifoCnt_q, ~rtsN_q, ctsOn,
                                        rxOn_q, txOn_q, txState_q == TX_SHIFT};
               default:    rdData_q <= 32'h0;
            endcase
         end
      end
   end

   // Configuration and sticky flags, set wins over clear
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         cfg_q  <= CFG_RST;
         baud_q <= BAUD_RST;
         evt_q  <= '0;
         err_q  <= '0;
      end else begin
         if (wrConfig) cfg_q <= ufc_cfg_s'(avs_writedata[6:0]);
         if (wrBaud) baud_q <= (avs_writedata[15:0] < BAUD_MIN) ? BAUD_MIN
                                                               : avs_writedata[15:0];
         evt_q <= evtSet | (evt_q & ~(wrEvents ? avs_writedata[3:0] : 4'h0));
         err_q <= errSet | (err_q & ~(wrErrsrc ? avs_writedata[2:0] : 3'h0));
      end
   end

   // Transmitter
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         txState_q <= TX_IDLE;
         {txOn_q, txSusp_q, txPend_q} <= 3'h0;
         txLine_q  <= 1'b1;
         txBuf_q   <= 8'h0;
         txSh_q    <= 11'h7ff;
         txCnt_q   <= 16'h0;
         txBit_q   <= 4'h0;
      end else begin
         if (wrTxd) begin
            txBuf_q  <= avs_writedata[7:0];
            txPend_q <= 1'b1;
         end else if (txLoad) begin
            txPend_q <= 1'b0;
         end
         if (start_transmit_task) txOn_q <= 1'b1;
         else if (stop_transmit_task | (txSusp_q & txState_q == TX_IDLE)) txOn_q <= 1'b0;
         if (suspend) txSusp_q <= 1'b1;
         else if (start_transmit_task | stop_transmit_task | txState_q == TX_IDLE) txSusp_q <= 1'b0;
         if (stop_transmit_task) begin
            txState_q <= TX_IDLE;
            txLine_q  <= 1'b1;
         end else begin
            case (txState_q)
               TX_IDLE: begin
                  txLine_q <= 1'b1;
                  if (txLoad) begin
                     txState_q <= TX_SHIFT;
                     txSh_q    <= cfg_q.parity ? {1'b1, txParity, txBuf_q, 1'b0}
                                               : {2'h3, txBuf_q, 1'b0};
                     txLine_q  <= 1'b0;
                     txCnt_q   <= baud_q - 16'h1;
                     txBit_q   <= 4'h0;
                  end
               end
               TX_SHIFT: begin
                  if (txCnt_q != 16'h0) begin
                     txCnt_q <= txCnt_q - 16'h1;
                  end else if (txEnd) begin
                     txState_q <= TX_IDLE;
                     txLine_q  <= 1'b1;
                  end else begin
                     txSh_q   <= {1'b1, txSh_q[10:1]};
                     txLine_q <= txSh_q[1];
                     txBit_q  <= txBit_q + 4'h1;
                     txCnt_q  <= baud_q - 16'h1;
                  end
               end
               default: txState_q <= TX_IDLE;
            endcase
         end
      end
   end

   // Receiver run state and stop window
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         rxOn_q  <= 1'b0;
         toCnt_q <= 24'h0;
      end else begin
         if (start_receive_task) begin
            rxOn_q  <= 1'b1;
            toCnt_q <= 24'h0;
         end else if (stop_receive_task & rxOn_q) begin
            rxOn_q  <= 1'b0;
            toCnt_q <= toLoad;
         end else if (toCnt_q != 24'h0) begin
            toCnt_q <= toCnt_q - 24'h1;
         end
      end
   end

   // Receive shifter, samples mid-bit
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         rxState_q <= RX_IDLE;
         rxCnt_q   <= 16'h0;
         rxBit_q   <= 4'h0;
         rxSh_q    <= 9'h0;
      end else begin
         if (rxCnt_q != 16'h0 && rxState_q != RX_IDLE && rxState_q != RX_HIGH) begin
            rxCnt_q <= rxCnt_q - 16'h1;
         end else begin
            case (rxState_q)
               RX_IDLE: if (rxActive & ~rxLine) begin
                  rxState_q <= RX_START;
                  rxCnt_q   <= {1'b0, baud_q[15:1]};
               end
               RX_START: begin
                  rxState_q <= rxLine ? RX_IDLE : RX_BITS;
                  rxCnt_q   <= baud_q - 16'h1;
                  rxBit_q   <= 4'h0;
               end
               RX_BITS: begin
                  rxCnt_q <= baud_q - 16'h1;
                  if (rxBit_q != rxData) begin
                     rxSh_q  <= {rxLine, rxSh_q[8:1]};
                     rxBit_q <= rxBit_q + 4'h1;
                  end else begin
                     rxState_q <= rxLine ? RX_IDLE : RX_BRK;
                  end
               end
               RX_BRK:  rxState_q <= rxLine ? RX_IDLE : RX_HIGH;
               RX_HIGH: if (rxLine) rxState_q <= RX_IDLE;
               default: rxState_q <= RX_IDLE;
            endcase
         end
      end
   end

   // Receive FIFO storage
   always_ff @(posedge core_clk) begin
      if (rxPush) fifoMem_q[wrPtr_q] <= rxByte;
   end

   // FIFO pointers, holding register and RTS
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         {wrPtr_q, rdPtr_q, fifoCnt_q} <= 9'h0;
         rxd_q      <= 8'h0;
         rxdValid_q <= 1'b0;
         rtsHold_q  <= 1'b0;
         rtsN_q     <= 1'b1;
      end else begin
         if (rxPush) wrPtr_q <= wrNext;
         if (fifoPop | (rxPush & fifoFull)) rdPtr_q <= rdNext;
         if (rxPush & ~fifoPop & ~fifoFull) fifoCnt_q <= fifoCnt_q + 3'h1;
         else if (fifoPop & ~rxPush) fifoCnt_q <= fifoCnt_q - 3'h1;
         if (rxdLoad) begin
            rxd_q      <= fifoMem_q[rdPtr_q];
            rxdValid_q <= 1'b1;
         end else if (rdRxd) begin
            rxdValid_q <= 1'b0;
         end
         if (fifoCnt_q >= RTS_LVL) rtsHold_q <= 1'b1;
         else if (fifoCnt_q == 3'h0 & ~rxdValid_q) rtsHold_q <= 1'b0;
         rtsN_q <= ~rtsOn;
      end
   end

   assign avs_readdata    = rdData_q;
   assign avs_waitrequest = waitReq_q;
   assign txdOut          = txLine_q;
   assign rtsNOut         = rtsN_q;

   // Pin drivers registered from the pin selection
   logic txdOe_q, rtsNOe_q;
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) {txdOe_q, rtsNOe_q} <= 2'h0;
      else {rtsNOe_q, txdOe_q} <= {2{cfg_q.enable}} & cfg_q.connect[3:2];
   end
   assign txdOe  = txdOe_q;
   assign rtsNOe = rtsNOe_q;

   // Checks
   a_rts_flow_off: assert property (@(posedge core_clk) disable iff (rst)
      !rst && !cfg_q.flow |=> !rtsN_q) else $error("RTS dropped without flow control");
   a_rts_fifo_room: assert property (@(posedge core_clk) disable iff (rst)
      cfg_q.flow && fifoCnt_q >= RTS_LVL |=> ##1 rtsN_q)
      else $error("RTS still asserted with FIFO nearly full");
   a_tx_start_low: assert property (@(posedge core_clk) disable iff (rst)
      $rose(txState_q == TX_SHIFT) |-> !txLine_q) else $error("No start bit");
   a_tx_needs_on: assert property (@(posedge core_clk) disable iff (rst)
      txState_q == TX_IDLE && !txOn_q |=> txState_q == TX_IDLE)
      else $error("Transmit began without start task");
   a_tx_stop_now: assert property (@(posedge core_clk) disable iff (rst)
      stop_transmit_task |=> txState_q == TX_IDLE && txLine_q) else $error("Stop did not halt");
   a_tx_stop_bit: assert property (@(posedge core_clk) disable iff (rst)
      txState_q == TX_SHIFT && txBit_q == txBits |-> txLine_q)
      else $error("Stop bit not high");
   a_tx_done_evt: assert property (@(posedge core_clk) disable iff (rst)
      txEnd |=> evt_q.txDone && txState_q == TX_IDLE) else $error("No done event");
   a_rx_needs_on: assert property (@(posedge core_clk) disable iff (rst)
      rxState_q == RX_IDLE && !rxActive |=> rxState_q == RX_IDLE)
      else $error("Receive began while stopped");
   a_fifo_bound: assert property (@(posedge core_clk) disable iff (rst)
      rxPush && fifoFull && !fifoPop |=> fifoCnt_q == DEPTH)
      else $error("FIFO count wrong on overwrite");
   a_rxd_ready: assert property (@(posedge core_clk) disable iff (rst)
      rxdLoad |=> evt_q.rxReady && rxdValid_q) else $error("No ready event on load");
endmodule // ufc_uart

// >>> rtl/ufc_pkg.sv
// Purpose: Shared constants and types for the flow-controlled UART
// Assumes: Word-aligned 32-bit Avalon-MM register map, byte offsets
// Notes:   Divisor is core clock cycles per serial bit
package ufc_pkg;
   // Register byte offsets
   localparam logic [7:0] OFF_TASKS  = 8'h00;
   localparam logic [7:0] OFF_EVENTS = 8'h04;
   localparam logic [7:0] OFF_ERRSRC = 8'h08;
   localparam logic [7:0] OFF_CONFIG = 8'h0c;
   localparam logic [7:0] OFF_BAUD   = 8'h10;
   localparam logic [7:0] OFF_RXD    = 8'h14;
   localparam logic [7:0] OFF_TXD    = 8'h18;
   localparam logic [7:0] OFF_STATUS = 8'h1c;
   // Task bit positions
   localparam int TB_START_RX = 0;
   localparam int TB_STOP_RX  = 1;
   localparam int TB_START_TX = 2;
   localparam int TB_STOP_TX  = 3;
   localparam int TB_SUSPEND  = 4;
   // Reset and minimum divisor values
   localparam logic [15:0] BAUD_RST = 16'h01b2;
   localparam logic [15:0] BAUD_MIN = 16'h0004;
   // Frame geometry
   localparam logic [3:0] DATA_BITS = 4'h8;
   // Bit times of the receive window after a stop
   localparam logic [7:0] RX_TO_BITS = 8'h37;

   typedef struct packed {
      logic       parity;
      logic       flow;
      logic [3:0] connect;  // rts, txd, cts, rxd
      logic       enable;
   } ufc_cfg_s;

   typedef struct packed {
      logic err;
      logic rxTimeout;
      logic rxReady;
      logic txDone;
   } ufc_evt_s;

   typedef struct packed {
      logic brk;
      logic parity;
      logic framing;
   } ufc_err_s;

   localparam ufc_cfg_s CFG_RST = '{parity: 1'b0, flow: 1'b0,
                                    connect: 4'hf, enable: 1'b0};
endpackage

// >>> test/ufc_far_uart.sv
// Purpose: Far-end UART model on the serial pins
// Assumes: Bit time of bitCyc core cycles, one stop bit
// Notes:   Bench sets parOn, flowOn and ctsNIn directly
`timescale 1ns/1ns
module ufc_far_uart (
   input  wire logic core_clk,
   input  wire logic txdOut,
   input  wire logic txdOe,
   input  wire logic rtsNOut,
   input  wire logic rtsNOe,
   output logic      rxdIn,
   output logic      ctsNIn
);
   int         bitCyc  = 8;
   int         sentOff = 0;
   logic       parOn   = 1'b0;
   logic       flowOn  = 1'b0;
   logic [7:0] gotQ[$];
   logic       okQ[$];
   logic [9:0] sh;
   // Undriven lines rest at their pull-up level
   wire lineTx  = txdOe ? txdOut : 1'b1;
   wire rtsHigh = !rtsNOe || rtsNOut;

   initial begin
      rxdIn  = 1'b1;
      ctsNIn = 1'b0;
   end

   // One frame; a low stop bit is left on the line
   task automatic send(input logic [7:0] b, input logic stopBit);
      logic [10:0] f;
      if (!rtsHigh) sentOff = 0;
      // Holds off after four bytes sent against a high RTS
      while (flowOn && rtsHigh && sentOff >= 4) begin
         @(posedge core_clk);
      end
      if (flowOn && rtsHigh) sentOff++;
      f = parOn ? {stopBit, ^b, b, 1'b0} : {1'b1, stopBit, b, 1'b0};
      for (int i = 0; i < 10 + parOn; i++) begin
         rxdIn <= f[i];
         repeat (bitCyc) @(posedge core_clk);
      end
   endtask

   // Sample each frame from the design at mid-bit
   always begin
      @(negedge lineTx);
      repeat (bitCyc / 2) @(posedge core_clk);
      for (int i = 0; i < 9 + parOn; i++) begin
         repeat (bitCyc) @(posedge core_clk);
         sh[i] = lineTx;
      end
      gotQ.push_back(sh[7:0]);
      okQ.push_back(sh[8 + parOn] === 1'b1 && (!parOn || sh[8] === ^sh[7:0]));
   end
endmodule // ufc_far_uart

// >>> test/testbench.sv
// Purpose: Self-checking bench for the flow-controlled UART
// Assumes: Far-end model on the pins, bit time cut to 8 cycles
// Notes:   Random bytes from a fixed seed plus corner cases
`timescale 1ns/1ns
module testbench;
   import ufc_pkg::*;
   localparam logic [2:0] A_TSK = OFF_TASKS[4:2];
   localparam logic [2:0] A_EVT = OFF_EVENTS[4:2];
   localparam logic [2:0] A_ERR = OFF_ERRSRC[4:2];
   localparam logic [2:0] A_CFG = OFF_CONFIG[4:2];
   localparam logic [2:0] A_RXD = OFF_RXD[4:2];
   localparam logic [2:0] A_TXD = OFF_TXD[4:2];
   localparam logic [2:0] A_STA = OFF_STATUS[4:2];
   logic        core_clk = 1'b0;
   logic        rst = 1'b1;
   logic [2:0]  avs_address = 3'h0;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata, q;
   logic        avs_waitrequest, rxdIn, ctsNIn, txdOut, txdOe, rtsNOut, rtsNOe;
   logic [7:0]  b [8];
   int          num_errors = 0;
   int          checked = 0;
   int          cyc = 0;

   ufc_uart #(.FIFO_DEPTH(6), .RTS_ROOM(4)) u_ufc_uart (.core_clk(core_clk), .rst(rst),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .rxdIn(rxdIn), .ctsNIn(ctsNIn), .txdOut(txdOut),
      .txdOe(txdOe), .rtsNOut(rtsNOut), .rtsNOe(rtsNOe));
   ufc_far_uart u_ufc_far_uart (.core_clk(core_clk), .txdOut(txdOut), .txdOe(txdOe),
      .rtsNOut(rtsNOut), .rtsNOe(rtsNOe), .rxdIn(rxdIn), .ctsNIn(ctsNIn));

   initial begin
      forever #10 core_clk = ~core_clk;
   end

   // CONFIG word to write: enabled, all pins connected
   function automatic logic [31:0] cfg(input logic flow, input logic par);
      return {25'h0, par, flow, 4'hf, 1'b1};
   endfunction

   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // One Avalon-MM access, held until waitrequest is seen low
   task automatic bus(input logic wr, input logic [2:0] a, input logic [31:0] d);
      @(posedge core_clk);
      avs_address   <= a;
      avs_writedata <= d;
      avs_write     <= wr;
      avs_read      <= !wr;
      // Only the bench timeout ends a wait that never answers
      do begin
         @(posedge core_clk);
      end while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
   endtask

   task automatic wr(input logic [2:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask

   task automatic rd(input logic [2:0] a);
      bus(1'b0, a, 32'h0);
   endtask

   task automatic trig(input int t);
      wr(A_TSK, 32'h1 << t);
   endtask

   // Poll for an event, then clear it
   task automatic wait_ev(input int e);
      int n;
      n = 0;
      do begin
         rd(A_EVT);
         n++;
      end while (q[e] !== 1'b1 && n < 400);
      chk(q[e], 1'b1);
      wr(A_EVT, 32'h1 << e);
   endtask

   // Ready event cleared before the read
   task automatic rx_get(input logic [7:0] e);
      wait_ev(1);
      rd(A_RXD);
      chk(q[7:0], e);
   endtask

   task automatic got(input logic [7:0] e);
      chk(u_ufc_far_uart.gotQ.pop_front(), e);
      chk(u_ufc_far_uart.okQ.pop_front(), 1'b1);
   endtask

   // Transmit line must stay idle high
   task automatic quiet(input int n);
      logic ok;
      ok = 1'b1;
      repeat (n) begin
         @(posedge core_clk);
         ok = ok & (txdOut === 1'b1);
      end
      chk(ok, 1'b1);
   endtask

   task automatic give_verdict;
      if (num_errors == 0 && checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // Cut a hang short
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         num_errors++;
         give_verdict;
      end
   end

   // Main sequence
   initial begin
      void'($urandom(32'h76369ccf));
      foreach (b[i]) b[i] = 8'($urandom);
      tick(2);
      rst <= 1'b0;
      tick(1);
      chk({avs_waitrequest, txdOut, txdOe, rtsNOut, rtsNOe}, 32'h1a);
      rd(A_CFG);
      chk(q, 32'h1e);
      wr(OFF_BAUD[4:2], 32'h8);
      wr(A_CFG, cfg(0, 0));
      wr(A_TXD, 32'h5a);
      quiet(100);
      trig(TB_START_TX);
      tick(150);
      u_ufc_far_uart.gotQ.delete();
      u_ufc_far_uart.okQ.delete();
      wr(A_EVT, 32'hf);
      // Random bytes, parity off then on
      for (int i = 0; i < 4; i++) begin
         u_ufc_far_uart.parOn = i[1];
         wr(A_CFG, cfg(0, i[1]));
         wr(A_TXD, {24'h0, b[i]});
         wait_ev(0);
         got(b[i]);
      end
      u_ufc_far_uart.parOn = 1'b0;
      wr(A_CFG, cfg(0, 0));
      // Stop-transmit cuts a byte short
      wr(A_TXD, 32'h0);
      tick(30);
      trig(TB_STOP_TX);
      tick(2);
      quiet(60);
      // CTS high holds the transmitter; a byte in flight completes
      trig(TB_START_TX);
      u_ufc_far_uart.ctsNIn <= 1'b1;
      wr(A_CFG, cfg(1, 0));
      u_ufc_far_uart.flowOn = 1'b1;
      u_ufc_far_uart.gotQ.delete();
      u_ufc_far_uart.okQ.delete();
      wr(A_EVT, 32'hf);
      wr(A_TXD, {24'h0, b[4]});
      quiet(100);
      u_ufc_far_uart.ctsNIn <= 1'b0;
      wait_ev(0);
      got(b[4]);
      wr(A_TXD, {24'h0, b[5]});
      tick(20);
      u_ufc_far_uart.ctsNIn <= 1'b1;
      wait_ev(0);
      got(b[5]);
      u_ufc_far_uart.ctsNIn <= 1'b0;
      // Receiver ignores the line until started
      u_ufc_far_uart.send(8'h3c, 1'b1);
      tick(10);
      rd(A_EVT);
      chk(q[1], 1'b0);
      trig(TB_START_RX);
      tick(4);
      chk({rtsNOe, rtsNOut}, 32'h2);
      // Three bytes: RXD plus two FIFO entries drop RTS
      for (int i = 0; i < 3; i++) u_ufc_far_uart.send(b[i], 1'b1);
      tick(8);
      chk(rtsNOut, 1'b1);
      rx_get(b[0]);
      chk(rtsNOut, 1'b1);
      rx_get(b[1]);
      rx_get(b[2]);
      tick(4);
      chk(rtsNOut, 1'b0);
      // Eight bytes unread: the eighth displaces the oldest queued
      wr(A_CFG, cfg(0, 0));
      u_ufc_far_uart.flowOn = 1'b0;
      foreach (b[i]) u_ufc_far_uart.send(b[i], 1'b1);
      tick(8);
      for (int i = 0; i < 8; i++) if (i != 1) rx_get(b[i]);
      rd(A_STA);
      chk(q[8:5], 4'h0);
      // Parity on: good frame passes, a wrong parity bit is flagged
      wr(A_CFG, cfg(0, 1));
      u_ufc_far_uart.parOn = 1'b1;
      u_ufc_far_uart.send(b[2], 1'b1);
      rx_get(b[2]);
      u_ufc_far_uart.parOn = 1'b0;
      u_ufc_far_uart.send(8'h03, 1'b1);
      rx_get(8'h03);
      rd(A_ERR);
      chk(q[2:0], 3'b010);
      wr(A_ERR, 32'h7);
      wr(A_CFG, cfg(0, 0));
      // Low stop bit, then a line held low past a frame
      u_ufc_far_uart.send(8'h55, 1'b0);
      u_ufc_far_uart.rxdIn <= 1'b1;
      tick(20);
      rd(A_ERR);
      chk(q[2:0], 3'b001);
      wr(A_ERR, 32'h7);
      u_ufc_far_uart.send(8'h00, 1'b0);
      tick(40);
      u_ufc_far_uart.rxdIn <= 1'b1;
      rd(A_ERR);
      chk(q[2:0], 3'b101);
      rd(A_EVT);
      chk(q[3], 1'b1);
      // Stop-receive drops RTS, then times out
      wr(A_CFG, cfg(1, 0));
      repeat (4) rd(A_RXD);
      wr(A_EVT, 32'hf);
      chk(rtsNOut, 1'b0);
      trig(TB_STOP_RX);
      tick(3);
      chk(rtsNOut, 1'b1);
      wait_ev(2);
      // Suspend stops the receiver at once and lets the byte finish, then transmit stops
      trig(TB_START_RX);
      wr(A_TXD, {24'h0, b[7]});
      tick(30);
      trig(TB_SUSPEND);
      tick(3);
      chk(rtsNOut, 1'b1);
      wait_ev(0);
      got(b[7]);
      wait_ev(2);
      rd(A_STA);
      chk(q[2:1], 2'b00);
      trig(TB_START_TX);
      wr(A_TXD, {24'h0, b[6]});
      wait_ev(0);
      got(b[6]);
      // Flow off: RTS held low and CTS ignored
      wr(A_CFG, cfg(0, 0));
      u_ufc_far_uart.ctsNIn <= 1'b1;
      tick(3);
      chk(rtsNOut, 1'b0);
      wr(A_TXD, {24'h0, b[3]});
      wait_ev(0);
      got(b[3]);
      // Disconnected or disabled pins stay undriven
      wr(A_CFG, 32'h1);
      tick(2);
      chk({txdOe, rtsNOe}, 2'b00);
      wr(A_CFG, 32'h1e);
      tick(2);
      chk({txdOe, rtsNOe}, 2'b00);
      wr(A_CFG, 32'h9);
      tick(2);
      chk({txdOe, rtsNOe}, 2'b10);
      give_verdict;
   end
endmodule // testbench
